// ### bench/rcw_checker.sv
`include "rcw_params.svh"
`timescale 1ns/1ns
`default_nettype none
module rcw_checker #(
   parameter int STARTUP_CYCLES = 3200,
   parameter int LOW_MIN_CYCLES = 100
) (
   input wire logic                   i_ref_clk,
   input wire logic                   i_rst_n,
   input wire logic                   i_supply_up,
   input wire logic                   i_ext_rst_n,
   input wire logic                   i_pin_reset_disable_fuse,
   input wire logic                   i_dog_always_on_fuse,
   input wire logic [2:0]             i_low_supply_level_fuses,
   input wire logic                   i_comparator_ref_select,
   input wire logic                   i_adc_enabled,
   input wire logic                   i_clock_monitor_on,
   input wire logic [`RCW_ADDR_W-1:0] i_addr,
   input wire logic                   i_rd,
   input wire logic [7:0]             o_rdata,
   input wire logic                   o_core_rst_n,
   input wire rcw_pkg::rst_phase_t    o_rst_phase,
   input wire logic                   o_ref_enable,
   input wire logic                   o_dog_irq
);
   import rcw_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   int unsigned stretch_q;   // cycles spent stretching, too long for a repetition
   // count the stretch phase so its length can be checked on exit
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stretch_q <= 0;
      end else begin
         stretch_q <= (o_rst_phase == PH_STRETCH) ? stretch_q + 1 : 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   chk_core_follows_phase: assert property (
      o_core_rst_n == (o_rst_phase == PH_RUN)) else $error("core reset disagrees with phase");
   chk_stretch_length: assert property (
      (o_rst_phase == PH_RUN) && ($past(o_rst_phase) == PH_STRETCH)
      |-> stretch_q == STARTUP_CYCLES) else $error("stretch length wrong");
   chk_hold_exit: assert property (
      o_rst_phase == PH_HOLD |=> o_rst_phase inside {PH_HOLD, PH_STRETCH})
      else $error("hold left without stretch");
   chk_run_exit: assert property (
      o_rst_phase == PH_RUN |=> o_rst_phase inside {PH_RUN, PH_HOLD})
      else $error("run left without hold");
   chk_pin_reset: assert property (
      (!i_ext_rst_n && !i_pin_reset_disable_fuse) [*3] |-> ##[0:2] o_rst_phase == PH_HOLD)
      else $error("pin low gave no reset");
   chk_supply_loss: assert property (
      (!i_supply_up) [*3] |-> ##[0:2] o_rst_phase == PH_HOLD) else $error("no supply reset");
   chk_status_upper: assert property (
      $past(i_rd) && ($past(i_addr) == `RCW_OFS_STATUS) |-> o_rdata[7:4] == 4'h0)
      else $error("status upper bits set");
   chk_ref_on: assert property (
      (i_comparator_ref_select || i_adc_enabled) |=> o_ref_enable) else $error("ref off");
   chk_ref_off: assert property (
      (i_low_supply_level_fuses == 3'h7 && !i_comparator_ref_select && !i_adc_enabled) [*4]
      |=> !o_ref_enable) else $error("ref left on");
   chk_monitor_irq: assert property (
      i_clock_monitor_on |-> !o_dog_irq) else $error("irq with clock monitor");
   chk_fuse_irq: assert property (
      i_dog_always_on_fuse [*4] |-> !o_dog_irq) else $error("irq with always-on fuse");
   cover property (o_dog_irq);
   cover property ($rose(o_rst_phase == PH_STRETCH));
   cover property ((!i_ext_rst_n && !i_pin_reset_disable_fuse) [*3]);
endmodule : rcw_checker
bind reset_control_and_watchdog rcw_checker #(
   .STARTUP_CYCLES(STARTUP_CYCLES), .LOW_MIN_CYCLES(LOW_MIN_CYCLES)
) u_rcw_checker (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_supply_up(i_supply_up),
   .i_ext_rst_n(i_ext_rst_n), .i_pin_reset_disable_fuse(i_pin_reset_disable_fuse),
   .i_dog_always_on_fuse(i_dog_always_on_fuse),
   .i_low_supply_level_fuses(i_low_supply_level_fuses),
   .i_comparator_ref_select(i_comparator_ref_select), .i_adc_enabled(i_adc_enabled),
   .i_clock_monitor_on(i_clock_monitor_on), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_core_rst_n(o_core_rst_n), .o_rst_phase(o_rst_phase), .o_ref_enable(o_ref_enable),
   .o_dog_irq(o_dog_irq)
);
`default_nettype wire

// ### bench/supply_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module supply_pin_model (
   input  wire logic i_ref_clk,
   output logic      o_supply_up,
   output logic      o_ext_rst_n,
   output logic      o_low_supply,
   output logic      o_dog_osc
);
   ////////////////////////////////////////////////////////////////////////////////
   // dog oscillator free-runs, unrelated in phase to the core clock
   initial begin
      o_supply_up  = 1'b1;
      o_ext_rst_n  = 1'b1;
      o_low_supply = 1'b0;
      o_dog_osc    = 1'b0;
      forever #43 o_dog_osc = ~o_dog_osc;
   end
   // one source active for n core cycles: 0 supply loss, 1 pin, else low supply
   task automatic pulse(input int src, input int n);
      @(posedge i_ref_clk);
      case (src)
         0: o_supply_up <= 1'b0;
         1: o_ext_rst_n <= 1'b0;
         default: o_low_supply <= 1'b1;
      endcase
      repeat (n) @(posedge i_ref_clk);
      o_supply_up  <= 1'b1;
      o_ext_rst_n  <= 1'b1;
      o_low_supply <= 1'b0;
   endtask : pulse
endmodule : supply_pin_model
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import rcw_pkg::*;
   logic        i_ref_clk, i_rst_n, pin_fuse, on_fuse, cmp, adc, mon, restart, vack;
   logic        reg_wr, reg_rd, supply_up, ext_rst_n, low_supply, dog_osc;
   logic        core_rst_n, ref_en, irq;
   logic [2:0]  lvl;
   logic [1:0]  addr;
   logic [7:0]  wdata, rdata;
   logic [31:0] rnd;        // xorshift state
   rst_phase_t  phase;
   int          num_errors, tests_run, exp_status;  // exp_status: modelled status
   supply_pin_model model (.i_ref_clk(i_ref_clk), .o_supply_up(supply_up),
      .o_ext_rst_n(ext_rst_n), .o_low_supply(low_supply), .o_dog_osc(dog_osc));
   reset_control_and_watchdog #(.STARTUP_CYCLES(8), .LOW_MIN_CYCLES(3)) dut (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_supply_up(supply_up),
      .i_ext_rst_n(ext_rst_n), .i_low_supply(low_supply), .i_dog_osc(dog_osc),
      .i_pin_reset_disable_fuse(pin_fuse), .i_dog_always_on_fuse(on_fuse),
      .i_low_supply_level_fuses(lvl), .i_comparator_ref_select(cmp), .i_adc_enabled(adc),
      .i_clock_monitor_on(mon), .i_dog_restart(restart), .i_dog_vector_ack(vack),
      .i_addr(addr), .i_wdata(wdata), .i_wr(reg_wr), .i_rd(reg_rd), .o_rdata(rdata),
      .o_core_rst_n(core_rst_n), .o_rst_phase(phase), .o_ref_enable(ref_en), .o_dog_irq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xorshift
   task check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : check
   task bus_write(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      addr   <= a;
      wdata  <= d;
      reg_wr <= 1'b1;
      @(posedge i_ref_clk);
      reg_wr <= 1'b0;
   endtask : bus_write
   // read data stand only in the cycle after the strobe
   task bus_read(input logic [1:0] a, input logic [7:0] exp);
      @(posedge i_ref_clk);
      addr   <= a;
      reg_rd <= 1'b1;
      @(posedge i_ref_clk);
      reg_rd <= 1'b0;
      #1 check(rdata, exp);
   endtask : bus_read
   // bounded wait on irq or core reset reaching a level
   task wait_sig(input bit use_irq, input logic want);
      int n;
      n = 0;
      while (((use_irq ? irq : core_rst_n) !== want) && n < 30000) begin
         @(posedge i_ref_clk);
         #1 n++;
      end
      if (n >= 30000) begin
         num_errors++;
         $display("unexpected at %0t: wait expired", $time);
      end
   endtask : wait_sig
   task pulse_in(input bit is_restart);
      @(posedge i_ref_clk);
      if (is_restart) restart <= 1'b1;
      else vack <= 1'b1;
      @(posedge i_ref_clk);
      restart <= 1'b0;
      vack    <= 1'b0;
   endtask : pulse_in
   task report_and_stop;
      if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_ref_clk = 1'b0;
      forever #10 i_ref_clk = ~i_ref_clk;
   end
   // cuts a hang short; the full run needs about 40000 cycles
   initial begin
      repeat (60000) @(posedge i_ref_clk);
      num_errors++;
      report_and_stop();
   end
   initial begin
      {i_rst_n, pin_fuse, on_fuse, cmp, adc, mon, restart, vack, reg_wr, reg_rd} = '0;
      {lvl, addr, wdata, num_errors, tests_run} = {3'h7, 2'h0, 8'h00, 64'h0};
      rnd = 32'h55a81a66;
      repeat (5) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      exp_status = 1;
      wait_sig(0, 1);
      bus_read(2'h0, exp_status[7:0]);
      rnd = xorshift(rnd);
      bus_write(2'h3, rnd[7:0]);
      bus_read(2'h3, 8'h00);
      bus_write(2'h0, 8'h00);
      exp_status = 0;
      bus_read(2'h0, exp_status[7:0]);
      model.pulse(1, 4);
      wait_sig(0, 0);
      wait_sig(0, 1);
      exp_status |= 2;
      bus_read(2'h0, exp_status[7:0]);
      bus_write(2'h0, 8'h00);
      exp_status = 0;
      // pin ignored while its disable fuse is programmed
      @(posedge i_ref_clk) pin_fuse <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      model.pulse(1, 4);
      repeat (4) @(posedge i_ref_clk);
      #1 check({7'h0, core_rst_n}, 8'h01);
      bus_read(2'h0, exp_status[7:0]);
      @(posedge i_ref_clk) pin_fuse <= 1'b0;
      lvl <= 3'h0;
      repeat (4) @(posedge i_ref_clk);
      model.pulse(2, 1);
      repeat (8) @(posedge i_ref_clk);
      bus_read(2'h0, exp_status[7:0]);
      model.pulse(2, 10);
      wait_sig(0, 0);
      wait_sig(0, 1);
      exp_status = 4;
      bus_read(2'h0, exp_status[7:0]);
      bus_write(2'h0, 8'h00);
      // reference gate over random sources
      for (int k = 0; k < 6; k++) begin
         rnd = xorshift(rnd);
         @(posedge i_ref_clk);
         lvl <= rnd[2] ? 3'h7 : 3'h0;
         cmp <= rnd[3];
         adc <= rnd[4];
         repeat (5) @(posedge i_ref_clk);
         #1 check({7'h0, ref_en}, {7'h0, !rnd[2] | rnd[3] | rnd[4]});
      end
      @(posedge i_ref_clk) lvl <= 3'h7;
      bus_write(2'h1, 8'h40);
      wait_sig(1, 1);
      bus_read(2'h1, 8'hc0);
      pulse_in(0);
      bus_read(2'h1, 8'h40);
      for (int k = 0; k < 12; k++) begin
         rnd = xorshift(rnd);
         repeat (600 + rnd[8:0]) @(posedge i_ref_clk);
         pulse_in(1);
      end
      #1 check({7'h0, irq}, 8'h00);
      bus_write(2'h1, 8'h48);
      wait_sig(1, 1);
      check({7'h0, core_rst_n}, 8'h01);
      wait_sig(0, 0);
      wait_sig(0, 1);
      exp_status = 8;
      bus_read(2'h0, exp_status[7:0]);
      bus_read(2'h1, 8'h08);
      bus_write(2'h1, 8'h18);
      bus_write(2'h1, 8'h00);
      bus_read(2'h1, 8'h08);
      bus_write(2'h0, 8'h00);
      pulse_in(1);
      bus_write(2'h1, 8'h18);
      bus_write(2'h1, 8'h01);
      bus_read(2'h1, 8'h01);
      bus_write(2'h1, 8'h18);
      repeat (6) @(posedge i_ref_clk);
      bus_read(2'h1, 8'h09);
      bus_write(2'h1, 8'h02);
      bus_read(2'h1, 8'h09);
      @(posedge i_ref_clk) on_fuse <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      bus_write(2'h1, 8'h40);
      bus_read(2'h1, 8'h09);
      @(posedge i_ref_clk) on_fuse <= 1'b0;
      mon <= 1'b1;
      bus_read(2'h1, 8'h09);
      @(posedge i_ref_clk) mon <= 1'b0;
      bus_write(2'h1, 8'h18);
      bus_write(2'h1, 8'h00);
      // supply loss wipes the pin flag and sets power-on
      model.pulse(1, 4);
      wait_sig(0, 1);
      model.pulse(0, 4);
      wait_sig(0, 0);
      wait_sig(0, 1);
      exp_status = 1;
      bus_read(2'h0, exp_status[7:0]);
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire

// ### design/rcw_params.svh
`ifndef RCW_PARAMS_SVH
`define RCW_PARAMS_SVH
// register offsets on the plain register port
`define RCW_ADDR_W            2
`define RCW_OFS_STATUS        2'h0
`define RCW_OFS_DOG_CTRL      2'h1
// reset_cause_status field positions
`define RCW_BIT_SUPPLY_UP     0
`define RCW_BIT_PIN_RST       1
`define RCW_BIT_LOW_SUPPLY    2
`define RCW_BIT_DOG_RST       3
// dog_control field positions
`define RCW_BIT_PRE0          0
`define RCW_BIT_PRE2          2
`define RCW_BIT_RST_EN        3
`define RCW_BIT_CHG_EN        4
`define RCW_BIT_PRE3          5
`define RCW_BIT_IRQ_EN        6
`define RCW_BIT_IRQ_FLAG      7
// reset values
`define RCW_STATUS_RST        4'h1
`define RCW_SYNC_RST          9'h1c2
`define RCW_FUSE_LVL_OFF      3'h7
// prescaler: base count, largest legal code
`define RCW_DOG_BASE_CYC      21'h000800
`define RCW_DOG_MAX_CODE      4'h9
// timing
`define RCW_CLK_PERIOD_NS     20
`define RCW_STARTUP_DELAY_US  64
`define RCW_LOW_SUPPLY_MIN_NS 2000
`define RCW_CHG_WINDOW_CYC    3'h4
`endif

// ### design/rcw_pkg.sv
package rcw_pkg;
   // internal reset sequencer phases, one-hot
   typedef enum logic [2:0] {
      PH_HOLD    = 3'b001,
      PH_STRETCH = 3'b010,
      PH_RUN     = 3'b100
   } rst_phase_t;
endpackage : rcw_pkg

// ### design/reset_control_and_watchdog.sv
// Implementation choices: the strobed register port and the address map.
`include "rcw_params.svh"
`timescale 1ns/1ns
`default_nettype none
module reset_control_and_watchdog #(
   parameter int STARTUP_CYCLES =
      (`RCW_STARTUP_DELAY_US * 1000) / `RCW_CLK_PERIOD_NS,
   parameter int LOW_MIN_CYCLES =
      (`RCW_LOW_SUPPLY_MIN_NS + `RCW_CLK_PERIOD_NS - 1) / `RCW_CLK_PERIOD_NS
) (
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_rst_n,
   // supply monitors, pin and fuses (asynchronous)
   input  wire logic                    i_supply_up,
   input  wire logic                    i_ext_rst_n,
   input  wire logic                    i_low_supply,
   input  wire logic                    i_dog_osc,
   input  wire logic                    i_pin_reset_disable_fuse,
   input  wire logic                    i_dog_always_on_fuse,
   input  wire logic [2:0]              i_low_supply_level_fuses,
   // same-clock inputs from neighbouring logic
   input  wire logic                    i_comparator_ref_select,
   input  wire logic                    i_adc_enabled,
   input  wire logic                    i_clock_monitor_on,
   input  wire logic                    i_dog_restart,
   input  wire logic                    i_dog_vector_ack,
   // register port
   input  wire logic [`RCW_ADDR_W-1:0]  i_addr,
   input  wire logic [7:0]              i_wdata,
   input  wire logic                    i_wr,
   input  wire logic                    i_rd,
   output logic      [7:0]              o_rdata,
   // results
   output logic                         o_core_rst_n,
   output rcw_pkg::rst_phase_t          o_rst_phase,
   output logic                         o_ref_enable,
   output logic                         o_dog_irq
);
   import rcw_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // last count value of a time-out; reserved codes clamp to the longest
   // comparing against the last count rather than the period keeps the
   // counter at 20 bits even for the longest time-out
   function automatic logic [19:0] dog_limit(input logic [3:0] code);
      logic [3:0]  c;
      logic [20:0] full;
      c    = (code > `RCW_DOG_MAX_CODE) ? `RCW_DOG_MAX_CODE : code;
      full = `RCW_DOG_BASE_CYC << c;
      return 20'(full - 21'h000001);
   endfunction : dog_limit

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers

   logic [8:0] sync1_q;       // first stage, read only by sync2_q
   logic [8:0] sync2_q;       // safe copies
   // bit layout of both stages:
   //   [8:6] level fuses, [5] always-on fuse, [4] pin-disable fuse,
   //   [3] dog oscillator, [2] low supply, [1] reset pin, [0] supply up
   // fuses are static, but syncing them too keeps every pin on one path
   logic       osc_prev_q;    // oscillator level one cycle ago

   // two flops on every input from outside the clock domain
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_q <= `RCW_SYNC_RST;
         sync2_q <= `RCW_SYNC_RST;
      end else begin
         sync1_q <= {i_low_supply_level_fuses, i_dog_always_on_fuse,
                     i_pin_reset_disable_fuse, i_dog_osc, i_low_supply,
                     i_ext_rst_n, i_supply_up};
         sync2_q <= sync1_q;
      end
   end

   logic       supply_up_s;   // power-on detector above threshold
   logic       ext_rst_n_s;   // reset pin level
   logic       low_supply_s;  // detector reports low supply
   logic       osc_s;         // dog oscillator level
   logic       pin_dis_s;     // pin-reset disable fuse programmed
   logic       always_on_s;   // dog always-on fuse programmed
   logic       bod_en;        // detector enabled by level fuses

   assign supply_up_s  = sync2_q[0];
   assign ext_rst_n_s  = sync2_q[1];
   assign low_supply_s = sync2_q[2];
   assign osc_s        = sync2_q[3];
   assign pin_dis_s    = sync2_q[4];
   assign always_on_s  = sync2_q[5];
   assign bod_en       = (sync2_q[8:6] != `RCW_FUSE_LVL_OFF);

   ////////////////////////////////////////////////////////////////////////
   // reset sources

   logic        por_act;      // supply below detection level
   logic        pin_act;      // pin held low and not fused off
   logic        bod_act_q;    // filtered low-supply reset
   logic [15:0] low_cnt_q;    // how long low supply has lasted
   logic        dog_pulse_q;  // one-cycle watchdog reset
   logic        any_src;      // some reset source active

   assign por_act = ~supply_up_s;
   assign pin_act = ~ext_rst_n_s & ~pin_dis_s;

   // dips shorter than the minimum detection time are swallowed
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         low_cnt_q <= 16'h0000;
         bod_act_q <= 1'b0;
      end else if (!(bod_en && low_supply_s)) begin
         low_cnt_q <= 16'h0000;                       // recovery ends it
         bod_act_q <= 1'b0;
      end else if (low_cnt_q == 16'(LOW_MIN_CYCLES - 1)) begin
         bod_act_q <= 1'b1;
      end else begin
         low_cnt_q <= low_cnt_q + 16'h0001;
      end
   end

   assign any_src = por_act | pin_act | bod_act_q | dog_pulse_q;

   ////////////////////////////////////////////////////////////////////////
   // internal reset sequencer

   rst_phase_t  phase_q;      // current phase
   rst_phase_t  phase_d;      // next phase
   logic [15:0] dly_cnt_q;    // start-up delay count
   logic        core_rst_n_q; // registered reset to the core
   logic        in_reset;     // core held in reset

   // sources arrive through two synchroniser flops, so re-assertion lags
   // by those two cycles plus the phase register; no clock, no reset
   // any active source drops straight into hold; release waits out the delay
   always_comb begin
      phase_d = phase_q;
      case (phase_q)
         PH_HOLD: begin
            if (!any_src) phase_d = PH_STRETCH;
         end
         PH_STRETCH: begin
            if (any_src) phase_d = PH_HOLD;
            else if (dly_cnt_q == 16'(STARTUP_CYCLES - 1)) phase_d = PH_RUN;
         end
         PH_RUN: begin
            if (any_src) phase_d = PH_HOLD;
         end
         default: phase_d = PH_HOLD;
      endcase
   end

   // phase register and delay counter
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase_q   <= PH_HOLD;
         dly_cnt_q <= 16'h0000;
      end else begin
         phase_q <= phase_d;
         if (phase_q == PH_STRETCH) dly_cnt_q <= dly_cnt_q + 16'h0001;
         else dly_cnt_q <= 16'h0000;
      end
   end

   // output flop so the core sees a clean level
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) core_rst_n_q <= 1'b0;
      else core_rst_n_q <= (phase_d == PH_RUN);
   end

   assign in_reset     = (phase_q != PH_RUN);
   assign o_core_rst_n = core_rst_n_q;
   assign o_rst_phase  = phase_q;

   ////////////////////////////////////////////////////////////////////////
   // reset_cause_status

   logic [3:0] status_q;      // dog, low supply, pin, power-on flags
   logic       wr_status;     // software write to the status register
   logic       wr_ctrl;       // software write to dog_control

   assign wr_status = i_wr && !in_reset && (i_addr == `RCW_OFS_STATUS);
   assign wr_ctrl   = i_wr && !in_reset && (i_addr == `RCW_OFS_DOG_CTRL);

   // a hardware set wins over a software zero in the same cycle
   // power-on wipes the other three flags and sets its own; the power-on
   // flag itself only falls to a software zero
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_q <= `RCW_STATUS_RST;
      end else if (por_act) begin
         status_q <= `RCW_STATUS_RST;
      end else begin
         if (dog_pulse_q) status_q[`RCW_BIT_DOG_RST] <= 1'b1;
         else if (wr_status && !i_wdata[`RCW_BIT_DOG_RST])
            status_q[`RCW_BIT_DOG_RST] <= 1'b0;
         if (bod_act_q) status_q[`RCW_BIT_LOW_SUPPLY] <= 1'b1;
         else if (wr_status && !i_wdata[`RCW_BIT_LOW_SUPPLY])
            status_q[`RCW_BIT_LOW_SUPPLY] <= 1'b0;
         if (pin_act) status_q[`RCW_BIT_PIN_RST] <= 1'b1;
         else if (wr_status && !i_wdata[`RCW_BIT_PIN_RST])
            status_q[`RCW_BIT_PIN_RST] <= 1'b0;
         if (wr_status && !i_wdata[`RCW_BIT_SUPPLY_UP])
            status_q[`RCW_BIT_SUPPLY_UP] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // dog_control

   logic       irq_flag_q;    // time-out interrupt pending
   logic       irq_en_q;      // interrupt enable as written
   logic       rst_en_q;      // reset enable as written
   logic [3:0] pre_q;         // prescaler code
   logic [2:0] chg_cnt_q;     // cycles left in the change window
   logic       chg_open;      // change window open
   logic       eff_rst_en;    // reset enable after overrides
   logic       eff_irq_en;    // interrupt enable after overrides
   logic       fire_irq;      // time-out raising the interrupt
   logic       fire_rst;      // time-out resetting the system
   logic       w_open;        // write that opens the window
   logic       w_commit;      // write that lands inside the window

   assign chg_open = (chg_cnt_q != 3'h0);
   assign w_open   = wr_ctrl && i_wdata[`RCW_BIT_CHG_EN] &&
                     i_wdata[`RCW_BIT_RST_EN];
   assign w_commit = wr_ctrl && chg_open && !i_wdata[`RCW_BIT_CHG_EN];

   // forced bits: dog flag, always-on fuse and clock monitor
   assign eff_rst_en = rst_en_q | status_q[`RCW_BIT_DOG_RST] |
                       always_on_s | i_clock_monitor_on;
   assign eff_irq_en = irq_en_q & ~always_on_s & ~i_clock_monitor_on;

   // window counter: closes four cycles after the opening write
   // a second opening write while open simply reloads the count
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) chg_cnt_q <= 3'h0;
      else if (in_reset || w_commit) chg_cnt_q <= 3'h0;
      else if (w_open) chg_cnt_q <= `RCW_CHG_WINDOW_CYC;
      else if (chg_open) chg_cnt_q <= chg_cnt_q - 3'h1;
   end

   // reset enable and prescaler only move freely inside the window
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_en_q <= 1'b0;
         pre_q    <= 4'h0;
      end else if (in_reset) begin
         rst_en_q <= 1'b0;
         pre_q    <= 4'h0;
      end else if (w_commit) begin
         rst_en_q <= i_wdata[`RCW_BIT_RST_EN];
         pre_q    <= {i_wdata[`RCW_BIT_PRE3], i_wdata[`RCW_BIT_PRE2:`RCW_BIT_PRE0]};
      end else if (wr_ctrl && i_wdata[`RCW_BIT_RST_EN]) begin
         rst_en_q <= 1'b1;                             // setting is never locked
      end
   end

   // interrupt enable and flag; a new time-out beats a clear
   // internal reset drops both so a stale request cannot outlive a reboot
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_en_q   <= 1'b0;
         irq_flag_q <= 1'b0;
      end else if (in_reset) begin
         irq_en_q   <= 1'b0;
         irq_flag_q <= 1'b0;
      end else begin
         if (fire_irq) irq_flag_q <= 1'b1;
         else if (i_dog_vector_ack) irq_flag_q <= 1'b0;
         else if (wr_ctrl && i_wdata[`RCW_BIT_IRQ_FLAG]) irq_flag_q <= 1'b0;
         if (wr_ctrl) irq_en_q <= i_wdata[`RCW_BIT_IRQ_EN];
         else if (i_dog_vector_ack && eff_rst_en) irq_en_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // watchdog counter

   logic        tick;         // one oscillator period elapsed
   logic [19:0] dog_cnt_q;    // oscillator cycles since restart
   logic        running;      // some mode other than stopped
   logic        timeout;      // count reached the selected limit

   assign tick    = osc_s & ~osc_prev_q;
   assign running = eff_rst_en | eff_irq_en;
   assign timeout = tick && running && (dog_cnt_q == dog_limit(pre_q));
   // combined mode resets only if the first interrupt was not serviced
   assign fire_rst = timeout && eff_rst_en && (!eff_irq_en || irq_flag_q);
   assign fire_irq = timeout && eff_irq_en;

   // edge detect on the synchronised oscillator
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) osc_prev_q <= 1'b0;
      else osc_prev_q <= osc_s;
   end

   // shortening the period below the count misses the limit until the counter wraps: restart first
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) dog_cnt_q <= 20'h00000;
      else if (in_reset || !running || i_dog_restart || timeout)
         dog_cnt_q <= 20'h00000;
      else if (tick) dog_cnt_q <= dog_cnt_q + 20'h00001;
   end

   // reset pulse lasts exactly one cycle; delay starts one cycle after it falls
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) dog_pulse_q <= 1'b0;
      else dog_pulse_q <= fire_rst;
   end

   // level request; also serves as the wake-up source
   assign o_dog_irq = irq_flag_q & eff_irq_en;

   ////////////////////////////////////////////////////////////////////////
   // read port and reference gate

   logic [7:0] rdata_q;       // read data, valid one cycle after strobe
   logic       ref_en_q;      // bandgap enable

   // unmapped offsets read zero; data stands one cycle only
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= 8'h00;
      end else if (i_rd && (i_addr == `RCW_OFS_STATUS)) begin
         rdata_q <= {4'h0, status_q};
      end else if (i_rd && (i_addr == `RCW_OFS_DOG_CTRL)) begin
         rdata_q <= {irq_flag_q, eff_irq_en, pre_q[3], chg_open,
                     eff_rst_en, pre_q[2:0]};
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // the reference costs power, so only on while something needs it
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) ref_en_q <= 1'b0;
      else ref_en_q <= bod_en | i_comparator_ref_select | i_adc_enabled;
   end

   assign o_rdata      = rdata_q;
   assign o_ref_enable = ref_en_q;

endmodule : reset_control_and_watchdog
`default_nettype wire
